//--- mwp_pkg.sv
// constants shared by the write-protect and register-map logic
// assumes one 25 MHz clock and a single-lane serial host on the pins
package mwp_pkg;

   // -------------------------------------------------------------
   // instruction opcodes
   // -------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_MEM_WRITE = 8'h02;
   localparam logic [7:0] OP_READ_ANY_REG = 8'h65;
   localparam logic [7:0] OP_WRITE_ANY_REG = 8'h71;

   // -------------------------------------------------------------
   // register addresses used by read/write any register
   // -------------------------------------------------------------
   localparam logic [23:0] REG_STATUS = 24'h000000;
   localparam logic [23:0] REG_INT_STATUS = 24'h000001;
   localparam logic [23:0] REG_CONFIG_ONE = 24'h000002;
   localparam logic [23:0] REG_CONFIG_TWO = 24'h000003;
   localparam logic [23:0] REG_INT_CONFIG = 24'h000004;
   localparam logic [23:0] REG_ECC_DATA_IN = 24'h000005;
   localparam logic [23:0] REG_ECC_INJECT = 24'h000006;
   localparam logic [23:0] REG_ECC_DATA_OUT = 24'h000007;
   localparam logic [23:0] REG_ECC_ERR_COUNT = 24'h000008;
   localparam logic [23:0] REG_EXT_ADDR = 24'h000009;
   localparam logic [23:0] REG_DEVICE_ID = 24'h000030;

   // -------------------------------------------------------------
   // field positions and reset values
   // -------------------------------------------------------------
   localparam int SR_WP_EN_POS = 7;
   localparam int SR_TB_POS = 5;
   localparam int SR_BP_HI = 4;
   localparam int SR_BP_LO = 2;
   localparam int SR_WEL_POS = 1;
   localparam int CR1_LOCK_POS = 2;
   localparam int CR1_WMODE_HI = 1;
   localparam int CR1_WMODE_LO = 0;
   localparam logic [7:0] CR1_RESET = 8'he0;
   localparam logic [7:0] CR1_WR_MASK = 8'he7;
   localparam int CR2_W = 4;
   localparam logic [3:0] CR2_RESET = 4'h8;
   localparam logic [7:0] INT_CFG_WR_MASK = 8'h0f;
   localparam int EXT_W = 5;
   localparam logic [1:0] WMODE_NORMAL = 2'h0;
   localparam logic [1:0] WMODE_SRAM = 2'h1;
   localparam logic [1:0] WMODE_BACK2BACK = 2'h2;

   // -------------------------------------------------------------
   // framing, protection and identity
   // -------------------------------------------------------------
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;
   localparam logic [3:0] LAT_LAST = 4'h1;
   localparam int ID_BYTE_LAST = 3;
   localparam logic [2:0] PROT_CODE_ALL = 3'h7;
   // value is arbitrary, not a real maker or part code
   localparam logic [31:0] DEVICE_ID_DEFAULT = 32'h5a2c_0101;
   // sync order: cs_b, sclk, mosi, wp_b, tb pin, protect pins 2..0
   localparam logic [7:0] SYNC_RESET = 8'h90;
   // host must wait this long after power-up; counted by the host
   localparam int POWER_UP_WAIT_US = 250;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_ADDR,
      ST_WAIT,
      ST_DATA,
      ST_SKIP
   } mwp_state_e;

endpackage

//--- mwp_sync.sv
// two-flop synchroniser for a group of asynchronous pin levels
// assumes the pins are slow against clk_i, as the serial clock is
`timescale 1ns/10ps
module mwp_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         meta_q <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

//--- mwp_range_check.sv
// decides whether an array address lies in a block-protected region
// assumes the address is the full array address, msb at ADDR_W-1
`timescale 1ns/10ps
module mwp_range_check #(
   parameter int ADDR_W = 29
) (
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [2:0] code_i,
   input wire logic bottom_i,
   output logic hit_o
);
   import mwp_pkg::*;

   // code 1 covers 1/64, each step doubles, code 7 covers all; the
   // region is the set of addresses whose top (7-code) bits are all
   // ones (top anchored) or all zeros (bottom anchored)
   function automatic logic in_region(input logic [ADDR_W-1:0] a,
                                      input logic [2:0] code,
                                      input logic bottom);
      logic ok;
      int span;
      ok = (code != 3'h0);
      span = int'(PROT_CODE_ALL) - int'(code);
      for (int i = 0; i < int'(PROT_CODE_ALL) - 1; i++) begin
         if (i < span && a[ADDR_W-1-i] == bottom) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   always_comb begin
      hit_o = in_region(addr_i, code_i, bottom_i);
   end
endmodule

//--- mwp_protect_core.sv
// serial register map, write-enable latch and array write protection
// assumes a mode-0 single-lane host clocked far below clk_i; the
// array itself sits outside and takes mem_wr_o as a write strobe
//
// Functional notes
// - any high protect pin blocks array writes in its selected region
// - all protect pins low give no pin-based array protection
// - top/bottom pin low anchors the region at the highest address
// - top/bottom pin high anchors the region at address zero
// - protect pins read low through reset, meaning no pin protection until they are sampled
// - pin code picks 1/64 up to all of the upper array, 000 none
// - bottom mode uses the same fractions counted from address zero
// - read any register decodes the fixed register address map
// - writes need the latch set, except array writes in sram mode; only the enable opcode sets it
// - back-to-back mode keeps the latch across array writes
// - latch is a read-only status bit, zero after reset
// - with pin-protect enabled, a low wp_b pin blocks register writes
// - software top/bottom bit: 0 top anchored, 1 bottom, reset 0
// - software protect field uses the pin code mapping, reset 000
// - software and pin protection are ORed per address
// - status bits six and zero read as zero
// - register writes need the latch and clear it at deselect
// - lock bit freezes the software top/bottom and protect fields
`timescale 1ns/10ps
module mwp_protect_core #(
   parameter int ADDR_W = 29,
   parameter logic [31:0] DEVICE_ID = mwp_pkg::DEVICE_ID_DEFAULT
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic cs_b_i,
   input wire logic sclk_i,
   input wire logic mosi_i,
   input wire logic wp_b_i,
   input wire logic hw_protect_pin_bit0_i,
   input wire logic hw_protect_pin_bit1_i,
   input wire logic hw_protect_pin_bit2_i,
   input wire logic hw_top_bottom_pin_i,
   output logic miso_o,
   output logic miso_oe_b_o,
   output logic mem_wr_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   output logic write_enable_latch_o
);
   import mwp_pkg::*;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      mwp_state_e st;
      logic sclk_prev;
      logic cs_prev;
      logic [2:0] bit_cnt;
      logic [1:0] byte_cnt;
      logic [7:0] shift_in;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [3:0] lat_cnt;
      logic [7:0] shift_out;
      logic miso;
      logic miso_oe_b;
      logic wp_en;
      logic sw_tb;
      logic [2:0] sw_bp;
      logic wel;
      logic [7:0] cr1;
      logic [CR2_W-1:0] cr2;
      logic [7:0] int_cfg;
      logic [7:0] ecc_in;
      logic [7:0] ecc_inj;
      logic [EXT_W-1:0] ext;
      logic reg_wr_seen;
      logic arr_wr_seen;
      logic mem_wr;
      logic [ADDR_W-1:0] mem_addr;
      logic [7:0] mem_data;
   } mwp_state_s;

   mwp_state_s q;
   mwp_state_s d;

   // -------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------
   logic [7:0] pins_async;
   logic [7:0] pins_s;
   logic cs_b_s;
   logic sclk_s;
   logic mosi_s;
   logic wp_b_s;
   logic hw_tb_s;
   logic [2:0] hw_code_s;

   assign pins_async = {cs_b_i, sclk_i, mosi_i, wp_b_i,
                        hw_top_bottom_pin_i, hw_protect_pin_bit2_i,
                        hw_protect_pin_bit1_i, hw_protect_pin_bit0_i};

   // protect pins start low, so the array is unprotected until the pins are sampled
   mwp_sync #(
      .W(8),
      .RST_VAL(SYNC_RESET)
   ) u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .async_i(pins_async),
      .sync_o(pins_s)
   );

   assign {cs_b_s, sclk_s, mosi_s, wp_b_s, hw_tb_s, hw_code_s} = pins_s;

   // -------------------------------------------------------------
   // address protection
   // -------------------------------------------------------------
   logic [ADDR_W-1:0] cur_addr;
   logic hw_hit;
   logic sw_hit;
   logic prot_hit;

   assign cur_addr = ADDR_W'({q.ext, q.addr});

   mwp_range_check #(
      .ADDR_W(ADDR_W)
   ) u_hw_range (
      .addr_i(cur_addr),
      .code_i(hw_code_s),
      .bottom_i(hw_tb_s),
      .hit_o(hw_hit)
   );

   mwp_range_check #(
      .ADDR_W(ADDR_W)
   ) u_sw_range (
      .addr_i(cur_addr),
      .code_i(q.sw_bp),
      .bottom_i(q.sw_tb),
      .hit_o(sw_hit)
   );

   assign prot_hit = hw_hit | sw_hit;

   // -------------------------------------------------------------
   // register read decode
   // -------------------------------------------------------------
   function automatic logic [7:0] status_byte(input mwp_state_s s);
      logic [7:0] b;
      b = 8'h00;
      b[SR_WP_EN_POS] = s.wp_en;
      b[SR_TB_POS] = s.sw_tb;
      b[SR_BP_HI:SR_BP_LO] = s.sw_bp;
      b[SR_WEL_POS] = s.wel;
      return b;
   endfunction

   // unmapped addresses and the ecc result registers read zero here;
   // the identity streams its bytes msb first on successive reads
   function automatic logic [7:0] reg_read(input logic [23:0] a,
                                           input logic [1:0] idx,
                                           input mwp_state_s s);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         REG_STATUS: r = status_byte(s);
         REG_CONFIG_ONE: r = s.cr1;
         REG_CONFIG_TWO: r = {{(8-CR2_W){1'b0}}, s.cr2};
         REG_INT_CONFIG: r = s.int_cfg;
         REG_ECC_DATA_IN: r = s.ecc_in;
         REG_ECC_INJECT: r = s.ecc_inj;
         REG_EXT_ADDR: r = {{(8-EXT_W){1'b0}}, s.ext};
         REG_DEVICE_ID: r = DEVICE_ID[8*(ID_BYTE_LAST-int'(idx)) +: 8];
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // -------------------------------------------------------------
   // frame decode and next state
   // -------------------------------------------------------------
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic byte_done;
   logic [7:0] byte_in;
   logic [1:0] wmode;
   logic mem_allow;
   logic reg_allow;
   logic is_read;

   assign sclk_rise = sclk_s & ~q.sclk_prev;
   assign sclk_fall = ~sclk_s & q.sclk_prev;
   assign cs_rise = cs_b_s & ~q.cs_prev;
   assign byte_done = (q.bit_cnt == BIT_LAST);
   assign byte_in = {q.shift_in[6:0], mosi_s};
   assign wmode = q.cr1[CR1_WMODE_HI:CR1_WMODE_LO];
   assign is_read = (q.opcode == OP_READ_ANY_REG);
   // sram mode skips the latch; the reserved mode acts as normal
   assign mem_allow = (wmode == WMODE_SRAM) || q.wel;
   assign reg_allow = q.wel && !(q.wp_en && !wp_b_s);

   always_comb begin
      d = q;
      d.mem_wr = 1'b0;
      d.sclk_prev = sclk_s;
      d.cs_prev = cs_b_s;
      if (cs_b_s) begin
         d.st = ST_IDLE;
         d.bit_cnt = 3'h0;
         d.byte_cnt = 2'h0;
         d.miso_oe_b = 1'b1;
         d.miso = 1'b0;
         if (cs_rise) begin
            // back-to-back and sram modes keep the latch after array writes
            if (q.reg_wr_seen || (q.arr_wr_seen &&
                wmode != WMODE_BACK2BACK && wmode != WMODE_SRAM)) begin
               d.wel = 1'b0;
            end
            d.reg_wr_seen = 1'b0;
            d.arr_wr_seen = 1'b0;
         end
      end else begin
         if (sclk_rise) begin
            d.shift_in = byte_in;
            d.bit_cnt = q.bit_cnt + 3'h1;
            unique case (q.st)
               ST_IDLE, ST_CMD: begin
                  d.st = ST_CMD;
                  if (byte_done) begin
                     d.opcode = byte_in;
                     d.byte_cnt = 2'h0;
                     d.st = ST_SKIP;
                     case (byte_in)
                        OP_WRITE_ENABLE: d.wel = 1'b1;
                        OP_WRITE_DISABLE: d.wel = 1'b0;
                        OP_MEM_WRITE,
                        OP_READ_ANY_REG,
                        OP_WRITE_ANY_REG: d.st = ST_ADDR;
                        default: d.st = ST_SKIP;
                     endcase
                  end
               end
               ST_ADDR: begin
                  if (byte_done) begin
                     d.addr = {q.addr[15:0], byte_in};
                     d.byte_cnt = q.byte_cnt + 2'h1;
                     if (q.byte_cnt == ADDR_BYTE_LAST) begin
                        d.byte_cnt = 2'h0;
                        if (!is_read) begin
                           d.st = ST_DATA;
                        end else if (q.cr2 == '0) begin
                           d.st = ST_DATA;
                           d.shift_out = reg_read(d.addr, 2'h0, q);
                        end else begin
                           d.st = ST_WAIT;
                           d.lat_cnt = q.cr2;
                        end
                     end
                  end
               end
               ST_WAIT: begin
                  // dummy clocks before read data; bits are not counted
                  d.bit_cnt = 3'h0;
                  d.lat_cnt = q.lat_cnt - 4'h1;
                  if (q.lat_cnt == LAT_LAST) begin
                     d.st = ST_DATA;
                     d.shift_out = reg_read(q.addr, 2'h0, q);
                  end
               end
               ST_DATA: begin
                  if (byte_done) begin
                     d.byte_cnt = q.byte_cnt + 2'h1;
                     if (is_read) begin
                        d.shift_out = reg_read(q.addr, d.byte_cnt, q);
                     end else if (q.opcode == OP_MEM_WRITE) begin
                        // each byte is checked at its own address
                        if (mem_allow && !prot_hit) begin
                           d.mem_wr = 1'b1;
                           d.mem_addr = cur_addr;
                           d.mem_data = byte_in;
                           d.arr_wr_seen = 1'b1;
                        end
                        d.addr = q.addr + 24'h1;
                     end else begin
                        if (q.wel) begin
                           d.reg_wr_seen = 1'b1;
                        end
                        if (reg_allow) begin
                           case (q.addr)
                              REG_STATUS: begin
                                 d.wp_en = byte_in[SR_WP_EN_POS];
                                 if (!q.cr1[CR1_LOCK_POS]) begin
                                    d.sw_tb = byte_in[SR_TB_POS];
                                    d.sw_bp = byte_in[SR_BP_HI:SR_BP_LO];
                                 end
                              end
                              REG_CONFIG_ONE:
                                 d.cr1 = byte_in & CR1_WR_MASK;
                              REG_CONFIG_TWO:
                                 d.cr2 = byte_in[CR2_W-1:0];
                              REG_INT_CONFIG:
                                 d.int_cfg = byte_in & INT_CFG_WR_MASK;
                              REG_ECC_DATA_IN: d.ecc_in = byte_in;
                              REG_ECC_INJECT: d.ecc_inj = byte_in;
                              REG_EXT_ADDR: d.ext = byte_in[EXT_W-1:0];
                              default: d.ecc_in = q.ecc_in;
                           endcase
                        end
                     end
                  end
               end
               ST_SKIP: d.st = ST_SKIP;
            endcase
         end
         // read data change on the falling edge, host samples late in the high half
         if (sclk_fall && q.st == ST_DATA && is_read) begin
            d.miso = q.shift_out[7];
            d.shift_out = {q.shift_out[6:0], 1'b0};
            d.miso_oe_b = 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.cs_prev <= 1'b1;
         q.miso_oe_b <= 1'b1;
         q.wel <= 1'b0;
         q.sw_tb <= 1'b0;
         q.sw_bp <= 3'h0;
         q.cr1 <= CR1_RESET;
         q.cr2 <= CR2_RESET;
      end else begin
         q <= d;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign miso_o = q.miso;
   assign miso_oe_b_o = q.miso_oe_b;
   assign mem_wr_o = q.mem_wr;
   assign mem_addr_o = q.mem_addr;
   assign mem_wdata_o = q.mem_data;
   assign write_enable_latch_o = q.wel;

endmodule

//--- mwp_host.sv
// serial host model driving the link pins of the protect core
// assumes a 320 ns link clock that stands low between frames
`timescale 1ns/10ps
module mwp_host (
   output logic cs_b_o,
   output logic sclk_o,
   output logic mosi_o,
   input wire logic miso_i
);
   logic [31:0] rx;

   initial begin
      cs_b_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b0;
      rx = 32'h0;
   end

   // bytes go out msb first; read data is taken late in the high half;
   // a frame lasts a whole number of clk periods, so every link edge
   // stays on a falling clk edge when the frame starts on one
   task automatic frame(input logic [7:0] q[$]);
      cs_b_o = 1'b0;
      #160;
      foreach (q[i]) begin
         for (int b = 7; b >= 0; b--) begin
            mosi_o = q[i][b];
            #160 sclk_o = 1'b1;
            #160 rx = {rx[30:0], miso_i};
            sclk_o = 1'b0;
         end
      end
      #160 cs_b_o = 1'b1;
      // released data line must not look like the last bit
      mosi_o = ~mosi_o;
      #200;
   endtask
endmodule

//--- mwp_protect_core_properties.sv
// port assertions for the protect core, bound at the foot
// assumes protect pins only change between frames
`timescale 1ns/10ps
module mwp_protect_core_properties #(
   parameter int ADDR_W = 29
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic cs_b_i,
   input wire logic hw_protect_pin_bit0_i,
   input wire logic hw_protect_pin_bit1_i,
   input wire logic hw_protect_pin_bit2_i,
   input wire logic hw_top_bottom_pin_i,
   input wire logic miso_oe_b_o,
   input wire logic mem_wr_o,
   input wire logic [ADDR_W-1:0] mem_addr_o,
   input wire logic write_enable_latch_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   logic [2:0] pins;
   logic [5:0] top6;
   logic tb;
   assign pins = {hw_protect_pin_bit2_i, hw_protect_pin_bit1_i,
                  hw_protect_pin_bit0_i};
   assign tb = hw_top_bottom_pin_i;
   assign top6 = mem_addr_o[ADDR_W-1 -: 6];

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_rst;
      $rose(rst_b_i) |-> !write_enable_latch_o && !mem_wr_o;
   endproperty
   a_rst: assert property (p_rst)
      else $error("latch or strobe up after reset");
   property p_pulse;
      mem_wr_o |=> !mem_wr_o;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("write strobe longer than one cycle");
   property p_all;
      (pins == 3'h7)[*8] |-> !mem_wr_o;
   endproperty
   a_all: assert property (p_all)
      else $error("write while whole array pin protected");
   property p_top_half;
      (pins == 3'h6 && !tb)[*8] ##0 mem_wr_o |-> !mem_addr_o[ADDR_W-1];
   endproperty
   a_top_half: assert property (p_top_half)
      else $error("write into protected upper half");
   property p_bot_half;
      (pins == 3'h6 && tb)[*8] ##0 mem_wr_o |-> mem_addr_o[ADDR_W-1];
   endproperty
   a_bot_half: assert property (p_bot_half)
      else $error("write into protected lower half");
   property p_top64;
      (pins == 3'h1 && !tb)[*8] ##0 mem_wr_o |-> top6 != 6'h3f;
   endproperty
   a_top64: assert property (p_top64)
      else $error("write into protected top sixty-fourth");
   property p_bot64;
      (pins == 3'h1 && tb)[*8] ##0 mem_wr_o |-> top6 != 6'h00;
   endproperty
   a_bot64: assert property (p_bot64)
      else $error("write into protected bottom sixty-fourth");
   property p_desel;
      cs_b_i[*8] |=> $stable(write_enable_latch_o);
   endproperty
   a_desel: assert property (p_desel)
      else $error("latch moved while deselected");
   property p_oe;
      cs_b_i[*5] |-> miso_oe_b_o;
   endproperty
   a_oe: assert property (p_oe)
      else $error("data output enabled while deselected");

   c_wr: cover property (mem_wr_o);
   c_wel: cover property ($rose(write_enable_latch_o));
   c_rd: cover property (!miso_oe_b_o);
endmodule

bind mwp_protect_core mwp_protect_core_properties #(.ADDR_W(ADDR_W))
   i_mwp_protect_core_properties (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .cs_b_i(cs_b_i), .hw_protect_pin_bit0_i(hw_protect_pin_bit0_i),
   .hw_protect_pin_bit1_i(hw_protect_pin_bit1_i),
   .hw_protect_pin_bit2_i(hw_protect_pin_bit2_i),
   .hw_top_bottom_pin_i(hw_top_bottom_pin_i),
   .miso_oe_b_o(miso_oe_b_o), .mem_wr_o(mem_wr_o),
   .mem_addr_o(mem_addr_o), .write_enable_latch_o(write_enable_latch_o));

//--- mwp_protect_core_tb.sv
// self-checking bench for the protect core and its serial host
// assumes the host model owns every link pin of the core
`timescale 1ns/10ps
module mwp_protect_core_tb;
   import mwp_pkg::*;
   localparam int AW = 29;
   logic clk, rst_b, wp_b, p0, p1, p2, tbp;
   logic cs_b, sclk, mosi, miso, mem_wr, wel, oe_b;
   logic [AW-1:0] maddr, last_a;
   logic [7:0] mdat, last_d;
   int fails, comparisons, nwr, cyc;

   mwp_protect_core #(.ADDR_W(AW)) i_mwp_protect_core (.clk_i(clk),
      .rst_b_i(rst_b), .cs_b_i(cs_b), .sclk_i(sclk), .mosi_i(mosi),
      .wp_b_i(wp_b), .hw_protect_pin_bit0_i(p0),
      .hw_protect_pin_bit1_i(p1), .hw_protect_pin_bit2_i(p2),
      .hw_top_bottom_pin_i(tbp), .miso_o(miso), .miso_oe_b_o(oe_b),
      .mem_wr_o(mem_wr), .mem_addr_o(maddr), .mem_wdata_o(mdat),
      .write_enable_latch_o(wel));
   // a released data line shows the inverse, so a read sampled outside
   // the enable window cannot match
   mwp_host i_mwp_host (.cs_b_o(cs_b), .sclk_o(sclk), .mosi_o(mosi),
      .miso_i(oe_b ? ~miso : miso));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (mem_wr === 1'b1) begin
         nwr++;
         last_a = maddr;
         last_d = mdat;
      end
      if (cyc == 100000) begin
         fails++;
         test_done();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      if (fails == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic prot(input logic [28:0] a, input logic [2:0] c,
                                 input logic bot);
      logic [29:0] sz;
      sz = 30'h1 << (AW - 7 + c);
      if (c == 3'h0)
         return 1'b0;
      if (c == 3'h7)
         return 1'b1;
      return bot ? ({1'b0, a} < sz) : ({1'b0, a} >= 30'h20000000 - sz);
   endfunction

   task automatic wreg(input logic [23:0] a, input logic [7:0] d);
      i_mwp_host.frame('{OP_WRITE_ENABLE});
      i_mwp_host.frame('{OP_WRITE_ANY_REG, a[23:16], a[15:8], a[7:0], d});
   endtask

   // one dummy byte matches the default read latency
   task automatic rreg(input logic [23:0] a, input int n);
      logic [7:0] q[$];
      q = '{OP_READ_ANY_REG, a[23:16], a[15:8], a[7:0], 8'h00};
      repeat (n) q.push_back(8'h00);
      i_mwp_host.frame(q);
   endtask

   task automatic awr(input logic [23:0] a, input logic [7:0] d);
      i_mwp_host.frame('{OP_MEM_WRITE, a[23:16], a[15:8], a[7:0], d});
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      logic [7:0] rv[10];
      rv = '{8'h00, 8'h00, CR1_RESET, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
             8'h00, 8'h00};
      for (int a = 0; a < 10; a++) begin
         rreg(24'(a), 1);
         check(i_mwp_host.rx[7:0], rv[a]);
      end
      rreg(REG_DEVICE_ID, 4);
      check(i_mwp_host.rx, DEVICE_ID_DEFAULT);
      // zero latency: data follows the last address bit directly
      wreg(REG_CONFIG_TWO, 8'h00);
      i_mwp_host.frame('{OP_READ_ANY_REG, 8'h00, 8'h00, 8'h02, 8'h00});
      check(i_mwp_host.rx[7:0], CR1_RESET);
      wreg(REG_CONFIG_TWO, 8'h08);
      rreg(24'h00000a, 1);
      check(i_mwp_host.rx[7:0], 8'h00);
   endtask

   task automatic t_wel();
      int n0;
      n0 = nwr;
      awr(24'h000123, 8'ha5);
      check(nwr - n0, 0);
      i_mwp_host.frame('{OP_WRITE_ENABLE});
      rreg(REG_STATUS, 1);
      check(i_mwp_host.rx[7:0], 8'h02);
      awr(24'h000123, 8'h5a);
      check(nwr - n0, 1);
      check(last_a, 29'h0000123);
      check(last_d, 8'h5a);
      check(wel, 1'b0);
   endtask

   task automatic t_b2b();
      int n0;
      wreg(REG_CONFIG_ONE, 8'he2);
      check(wel, 1'b0);
      i_mwp_host.frame('{OP_WRITE_ENABLE});
      n0 = nwr;
      awr(24'h000200, 8'h11);
      awr(24'h000201, 8'h22);
      check(nwr - n0, 2);
      check(wel, 1'b1);
      i_mwp_host.frame('{OP_WRITE_DISABLE});
      check(wel, 1'b0);
   endtask

   task automatic t_lock();
      wreg(REG_CONFIG_ONE, 8'he5);
      wreg(REG_STATUS, 8'hff);
      rreg(REG_STATUS, 1);
      check(i_mwp_host.rx[7:0], 8'h80);
      wreg(REG_CONFIG_ONE, 8'he1);
      wreg(REG_STATUS, 8'hff);
      rreg(REG_STATUS, 1);
      check(i_mwp_host.rx[7:0], 8'hbc);
      @(negedge clk);
      wp_b = 1'b0;
      wreg(REG_STATUS, 8'h00);
      rreg(REG_STATUS, 1);
      check(i_mwp_host.rx[7:0], 8'hbc);
      @(negedge clk);
      wp_b = 1'b1;
      wreg(REG_STATUS, 8'h00);
      rreg(REG_STATUS, 1);
      check(i_mwp_host.rx[7:0], 8'h00);
   endtask

   // sram mode, so each probe write needs no latch of its own
   task automatic t_prot();
      logic [2:0] hc, sc;
      logic ht, st;
      logic [28:0] a;
      int n0;
      wreg(REG_CONFIG_ONE, 8'he1);
      for (int e = 0; e < 2; e++) begin
         wreg(REG_EXT_ADDR, e ? 8'h1f : 8'h00);
         for (int k = 0; k < 25; k++) begin
            hc = (k < 16) ? k[2:0] : {2'h0, k == 24};
            ht = (k < 16) && k[3];
            sc = (k < 16) ? 3'h0 : ((k == 24) ? 3'h1 : k[2:0]);
            st = (k >= 16) && (k[0] || k == 24);
            @(negedge clk);
            {p2, p1, p0, tbp} = {hc, ht};
            wreg(REG_STATUS, {2'h0, st, sc, 2'h0});
            for (int j = 0; j < 2; j++) begin
               a[28:24] = e ? 5'h1f : 5'h00;
               a[23:0] = (j == 0) ? 24'h7fffff : (e ? 24'hffffff : 24'h800000);
               n0 = nwr;
               awr(a[23:0], 8'(k));
               check(nwr - n0, !(prot(a, hc, ht) || prot(a, sc, st)));
            end
         end
      end
   endtask

   initial begin
      rst_b = 1'b0;
      wp_b = 1'b1;
      {p2, p1, p0, tbp} = 4'h0;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      repeat (6250) @(negedge clk);
      t_regs();
      t_wel();
      t_b2b();
      t_lock();
      t_prot();
      test_done();
   end
endmodule
